// File: verilog/port_output_or_and_sleep_ops.sv
// executes port writes, accumulator or-with-memory and the armed sleep entry.
// assumes op_code/op_valid, mem_rdata and load strobes come from the core on
// clk_sys; mem_rdata is the data word already selected by data_pointer.
// wake_pin is asynchronous and is synchronised here.
`timescale 1ns/1ps
// Summary of operation
// - port-zero write copies accumulator, carry kept
// - port-one write copies accumulator, carry kept
// - or memory word into accumulator, one cycle
// - halt instruction enters clock-keep low-power state
// - halt takes effect only right after arming
// - unarmed halt acts as no-operation
module port_output_or_and_sleep_ops #(
  parameter int ACC_W = core_ops_pkg::ACC_W_DEF,
  parameter int PC_W = core_ops_pkg::PC_W_DEF
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic op_valid,
  input core_ops_pkg::op_t op_code,
  input wire logic [ACC_W-1:0] mem_rdata,
  input wire logic acc_load,
  input wire logic [ACC_W-1:0] acc_load_data,
  input wire logic carry_load,
  input wire logic carry_load_data,
  input wire logic wake_pin,
  output logic [ACC_W-1:0] output_port_zero,
  output logic [ACC_W-1:0] output_port_one,
  output logic [ACC_W-1:0] acc_q,
  output logic carry_flag_q,
  output logic [PC_W-1:0] pc_q,
  output logic sleep_armed_q,
  output logic clock_keep_q
);
  import core_ops_pkg::*;

  // widths below one bit leave nothing to latch or count
  if (ACC_W < 1 || PC_W < 1) begin : g_bad_width
    $error("widths must be at least one bit");
  end

  logic wake_meta_q;
  logic wake_sync_q;
  logic exec;
  logic port_zero_load;
  logic port_one_load;
  logic [ACC_W-1:0] acc_d;
  logic carry_flag_d;
  logic [PC_W-1:0] pc_d;
  logic sleep_armed_d;
  logic clock_keep_d;

  // wake comes off a pin; first stage feeds only the second
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wake_meta_q <= 1'b0;
      wake_sync_q <= 1'b0;
    end else begin
      wake_meta_q <= wake_pin;
      wake_sync_q <= wake_meta_q;
    end
  end

  // no instruction retires while the clock-keep state holds
  assign exec = op_valid && !clock_keep_q;
  assign port_zero_load = exec && (op_code == op_port_zero_write);
  assign port_one_load = exec && (op_code == op_port_one_write);

  always_comb begin
    acc_d = acc_q;
    carry_flag_d = carry_flag_q;
    pc_d = pc_q;
    sleep_armed_d = sleep_armed_q;
    clock_keep_d = clock_keep_q;
    if (clock_keep_q) begin
      // arming cannot survive a halt, so a stray halt after wake is a no-op
      sleep_armed_d = 1'b0;
      if (wake_sync_q) begin
        clock_keep_d = 1'b0;
      end
    end else if (exec) begin
      pc_d = pc_q + PC_W'(PC_STEP);
      sleep_armed_d = (op_code == op_sleep_arm);
      case (op_code)
        op_or_mem: begin
          acc_d = acc_q | mem_rdata;
        end
        op_clock_keep_halt: begin
          clock_keep_d = sleep_armed_q;
        end
        op_other: begin
          if (acc_load) begin
            acc_d = acc_load_data;
          end
          if (carry_load) begin
            carry_flag_d = carry_load_data;
          end
        end
        default: begin
          // port writes, arming and nop leave accumulator and carry alone
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      acc_q <= ACC_W'(ACC_RST);
      carry_flag_q <= 1'b0;
      pc_q <= '0;
      sleep_armed_q <= 1'b0;
      clock_keep_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      carry_flag_q <= carry_flag_d;
      pc_q <= pc_d;
      sleep_armed_q <= sleep_armed_d;
      clock_keep_q <= clock_keep_d;
    end
  end

  out_port_reg #(.W(ACC_W)) u_port_zero (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .load(port_zero_load),
    .din(acc_q),
    .dout_q(output_port_zero)
  );

  out_port_reg #(.W(ACC_W)) u_port_one (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .load(port_one_load),
    .din(acc_q),
    .dout_q(output_port_one)
  );

  sequence s_arm;
    exec && op_code == op_sleep_arm;
  endsequence

  sequence s_halt;
    exec && op_code == op_clock_keep_halt;
  endsequence

  property p_port_zero;
    @(posedge clk_sys) disable iff (!arst_n)
    (exec && op_code == op_port_zero_write) |=>
      output_port_zero == $past(acc_q) && carry_flag_q == $past(carry_flag_q);
  endproperty
  a_port_zero: assert property (p_port_zero) else $error("port zero not loaded from accumulator");

  property p_port_one;
    @(posedge clk_sys) disable iff (!arst_n)
    (exec && op_code == op_port_one_write) |=>
      output_port_one == $past(acc_q) && carry_flag_q == $past(carry_flag_q)
      && output_port_zero == $past(output_port_zero);
  endproperty
  a_port_one: assert property (p_port_one) else $error("port one not loaded from accumulator");

  property p_or_mem;
    @(posedge clk_sys) disable iff (!arst_n)
    (exec && op_code == op_or_mem) |=>
      acc_q == ($past(acc_q) | $past(mem_rdata)) && carry_flag_q == $past(carry_flag_q)
      && pc_q == $past(pc_q) + PC_W'(PC_STEP);
  endproperty
  a_or_mem: assert property (p_or_mem) else $error("or result wrong");

  property p_armed_halt;
    @(posedge clk_sys) disable iff (!arst_n)
    s_arm ##1 s_halt |=> clock_keep_q;
  endproperty
  a_armed_halt: assert property (p_armed_halt) else $error("armed halt did not enter clock-keep");

  property p_halt_needs_arm;
    @(posedge clk_sys) disable iff (!arst_n)
    $rose(clock_keep_q) |-> $past(sleep_armed_q) && $past(op_code) == op_clock_keep_halt;
  endproperty
  a_halt_needs_arm: assert property (p_halt_needs_arm) else $error("clock-keep entered without arming");

  property p_unarmed_nop;
    @(posedge clk_sys) disable iff (!arst_n)
    (s_halt and !sleep_armed_q) |=>
      !clock_keep_q && pc_q == $past(pc_q) + PC_W'(PC_STEP) && acc_q == $past(acc_q)
      && carry_flag_q == $past(carry_flag_q);
  endproperty
  a_unarmed_nop: assert property (p_unarmed_nop) else $error("unarmed halt was not a no-op");

  property p_arm_cleared;
    @(posedge clk_sys) disable iff (!arst_n)
    (exec && op_code != op_sleep_arm) |=> !sleep_armed_q;
  endproperty
  a_arm_cleared: assert property (p_arm_cleared) else $error("arming outlived next instruction");

  property p_arm_then_other;
    @(posedge clk_sys) disable iff (!arst_n)
    s_arm ##1 (exec && op_code != op_sleep_arm) ##1 s_halt |=> !clock_keep_q;
  endproperty
  a_arm_then_other: assert property (p_arm_then_other) else $error("late halt still took arming");

  sequence s_asleep;
    clock_keep_q && !wake_sync_q;
  endsequence

  // a sleeping core retires nothing, whatever op_valid shows
  property p_asleep_frozen;
    @(posedge clk_sys) disable iff (!arst_n)
    s_asleep |=> clock_keep_q && pc_q == $past(pc_q) && acc_q == $past(acc_q)
      && carry_flag_q == $past(carry_flag_q);
  endproperty
  a_asleep_frozen: assert property (p_asleep_frozen) else $error("state moved in clock-keep");

  property p_wake_exit;
    @(posedge clk_sys) disable iff (!arst_n)
    (clock_keep_q && wake_sync_q) |=> !clock_keep_q && !sleep_armed_q;
  endproperty
  a_wake_exit: assert property (p_wake_exit) else $error("wake did not leave clock-keep");

  property p_arm_set;
    @(posedge clk_sys) disable iff (!arst_n)
    s_arm |=> sleep_armed_q && !clock_keep_q;
  endproperty
  a_arm_set: assert property (p_arm_set) else $error("arming not recorded");

  // load strobes belong to other instructions only
  property p_loads_ignored;
    @(posedge clk_sys) disable iff (!arst_n)
    (exec && op_code != op_other && op_code != op_or_mem) |=>
      acc_q == $past(acc_q) && carry_flag_q == $past(carry_flag_q);
  endproperty
  a_loads_ignored: assert property (p_loads_ignored) else $error("load strobe leaked into this op");
endmodule : port_output_or_and_sleep_ops

// File: verilog/core_ops_pkg.sv
// shared constants and opcode enumeration for the output/or/sleep executor,
// plus the small output latch it instantiates once per parallel port.
// assumes a single clk_sys domain and asynchronous active-low arst_n.
`timescale 1ns/1ps
package core_ops_pkg;
  typedef enum logic [2:0] {
    op_nop,
    op_port_zero_write,
    op_port_one_write,
    op_or_mem,
    op_sleep_arm,
    op_clock_keep_halt,
    op_other
  } op_t;
  localparam int ACC_W_DEF = 4;
  localparam int PC_W_DEF = 11;
  localparam int PC_STEP = 1;
  localparam int ACC_RST = 0;
  localparam int PORT_RST = 0;
  localparam int SYNC_STAGES = 2;
endpackage : core_ops_pkg

module out_port_reg #(
  parameter int W = core_ops_pkg::ACC_W_DEF
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic load,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout_q
);
  import core_ops_pkg::*;
  logic [W-1:0] dout_d;

  always_comb begin
    dout_d = load ? din : dout_q;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dout_q <= W'(PORT_RST);
    end else begin
      dout_q <= dout_d;
    end
  end
endmodule : out_port_reg

// File: test/port_sink.sv
// partner: the external devices hanging on the two output ports.
// assumes the ports are registered on clk_sys; latches what it last saw.
`timescale 1ns/1ps
module port_sink (
  input wire logic clk_sys,
  input wire logic [3:0] port_zero,
  input wire logic [3:0] port_one,
  output logic [3:0] seen_zero,
  output logic [3:0] seen_one
);
  // latches one edge late, like a real receiving register
  always_ff @(posedge clk_sys) begin
    seen_zero <= port_zero;
    seen_one <= port_one;
  end
endmodule : port_sink

// File: test/port_output_or_and_sleep_ops_bench.sv
// self-checking bench for the port/or/sleep executor.
// assumes default widths (acc 4, pc 11) and the port_sink partner.
`timescale 1ns/1ps
module port_output_or_and_sleep_ops_bench;
  import core_ops_pkg::*;
  logic clk_sys, arst_n, op_valid, acc_load, carry_load, carry_load_data, wake_pin;
  op_t op_code;
  logic [3:0] mem_rdata, acc_load_data, out_zero, out_one, acc_q, s0, s1;
  logic carry_flag_q, sleep_armed_q, clock_keep_q;
  logic [10:0] pc_q, pc_e;
  int num_errors, samples_checked;
  port_output_or_and_sleep_ops dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .op_valid(op_valid),
    .op_code(op_code), .mem_rdata(mem_rdata), .acc_load(acc_load), .acc_load_data(acc_load_data),
    .carry_load(carry_load), .carry_load_data(carry_load_data), .wake_pin(wake_pin),
    .output_port_zero(out_zero), .output_port_one(out_one), .acc_q(acc_q), .carry_flag_q(carry_flag_q),
    .pc_q(pc_q), .sleep_armed_q(sleep_armed_q), .clock_keep_q(clock_keep_q));
  port_sink sink_u (.clk_sys(clk_sys), .port_zero(out_zero), .port_one(out_one), .seen_zero(s0), .seen_one(s1));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task summarize;
    if (num_errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  task bad(input string msg);
    num_errors++;
    $display("BAD %0t %s", $time, msg);
  endtask : bad
  // loads are offered with every op so that ignoring them is exercised too
  task step(input op_t op, input logic [3:0] m, input logic [3:0] d);
    op_valid <= 1'b1;
    op_code <= op;
    mem_rdata <= m;
    acc_load <= 1'b1;
    acc_load_data <= d;
    carry_load <= 1'b1;
    carry_load_data <= d[0];
    pc_e = pc_e + 11'h001;
    @(posedge clk_sys);
  endtask : step
  task idle;
    op_valid <= 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : idle
  task t_ports;
    @(posedge clk_sys);
    step(op_other, 4'h0, 4'h9);
    step(op_port_zero_write, 4'h0, 4'h6);
    step(op_port_one_write, 4'h0, 4'h2);
    idle;
    samples_checked++;
    if (!(out_zero === 4'h9 && s0 === 4'h9)) bad("port zero");
    samples_checked++;
    if (!(out_one === 4'h9 && s1 === 4'h9)) bad("port one");
    samples_checked++;
    if (!(carry_flag_q === 1'b1 && acc_q === 4'h9 && pc_q === pc_e)) bad("carry or pc");
  endtask : t_ports
  task t_or;
    @(posedge clk_sys);
    step(op_or_mem, 4'h5, 4'h0);
    idle;
    samples_checked++;
    if (!(acc_q === 4'hd && carry_flag_q === 1'b1 && pc_q === pc_e)) bad("or");
  endtask : t_or
  task t_halt;
    @(posedge clk_sys);
    step(op_clock_keep_halt, 4'h0, 4'h0);
    idle;
    samples_checked++;
    if (!(clock_keep_q === 1'b0 && pc_q === pc_e && acc_q === 4'hd && carry_flag_q === 1'b1)) bad("unarmed halt");
    @(posedge clk_sys);
    step(op_sleep_arm, 4'h0, 4'h0);
    step(op_nop, 4'h0, 4'h0);
    step(op_clock_keep_halt, 4'h0, 4'h0);
    idle;
    samples_checked++;
    if (!(clock_keep_q === 1'b0 && sleep_armed_q === 1'b0 && pc_q === pc_e)) bad("stale arm");
  endtask : t_halt
  task t_sleep;
    @(posedge clk_sys);
    step(op_sleep_arm, 4'h0, 4'h0);
    step(op_clock_keep_halt, 4'h0, 4'h0);
    idle;
    samples_checked++;
    if (!(clock_keep_q === 1'b1 && pc_q === pc_e)) bad("sleep");
    @(posedge clk_sys);
    step(op_other, 4'h0, 4'h3);
    idle;
    pc_e = pc_e - 11'h001;
    samples_checked++;
    if (!(acc_q === 4'hd && pc_q === pc_e && clock_keep_q === 1'b1)) bad("op taken asleep");
    @(posedge clk_sys);
    wake_pin <= 1'b1;
    repeat (4) @(posedge clk_sys);
    wake_pin <= 1'b0;
    @(negedge clk_sys);
    samples_checked++;
    if (!(clock_keep_q === 1'b0)) bad("wake");
  endtask : t_sleep
  // reset in mid-run must drop a pending arming, so the halt after it is a no-op
  task t_mid_reset;
    @(posedge clk_sys);
    step(op_sleep_arm, 4'h0, 4'h0);
    op_valid <= 1'b0;
    arst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    pc_e = '0;
    step(op_clock_keep_halt, 4'h0, 4'h0);
    idle;
    samples_checked++;
    if (!(clock_keep_q === 1'b0 && sleep_armed_q === 1'b0 && pc_q === pc_e)) bad("reset kept arming");
    samples_checked++;
    if (!({out_zero, out_one, acc_q, carry_flag_q} === '0)) bad("mid-run reset");
  endtask : t_mid_reset
  initial begin
    #200us;
    num_errors++;
    summarize;
  end
  initial begin
    {arst_n, op_valid, acc_load, carry_load, carry_load_data, wake_pin} = '0;
    op_code = op_nop;
    {mem_rdata, acc_load_data} = '0;
    pc_e = '0;
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(negedge clk_sys);
    samples_checked++;
    if (!({out_zero, out_one, acc_q, carry_flag_q, pc_q, sleep_armed_q, clock_keep_q} === '0)) bad("reset");
    t_ports;
    t_or;
    t_halt;
    t_sleep;
    t_mid_reset;
    summarize;
  end
endmodule : port_output_or_and_sleep_ops_bench
